// File: lpmc_ext0_edge.sv
// Falling-edge sampler for external interrupt zero
module lpmc_ext0_edge (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sample_en,
  input wire logic pin_n,
  output logic fall
);
  import lpmc_pkg::*;

  logic smp;
  logic hit;

  // ----------------------------------------
  // Sampling
  // ----------------------------------------
  // Only sample points matter: short pulses between them vanish
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      smp <= 1'b1;
    end else if (sample_en) begin
      smp <= pin_n;
    end
  end

  // High then low across two samples marks an edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hit <= 1'b0;
    end else if (sample_en) begin
      hit <= smp & ~pin_n;
    end
  end

  // Reported one sample later, at the second strobe after the edge
  assign fall = sample_en & hit;

endmodule : lpmc_ext0_edge

// File: lpmc_far_model.sv
// Subclock, timer A overflow and external pin source model
module lpmc_far_model #(
  parameter int SUB_DIV = 4
) (
  input wire logic sys_clk,
  input wire logic ovf_go,
  input wire logic align,
  input wire logic ext_lvl,
  input wire logic irq_strobe,
  output logic subclk_tick,
  output logic timer_a_ovf,
  output logic ext_zero_n
);
  timeunit 1ns;
  timeprecision 1ns;
  int div_cnt = 0;
  logic pend = 1'b0;
  initial begin
    subclk_tick = 1'b0;
    ext_zero_n = 1'b1;
  end
  // Crystal keeps running through reset
  always @(posedge sys_clk) begin
    div_cnt <= (div_cnt == SUB_DIV - 1) ? 0 : div_cnt + 1;
    subclk_tick <= (div_cnt == SUB_DIV - 1);
    ext_zero_n <= ext_lvl;
    pend <= ovf_go | (pend & ~timer_a_ovf);
  end
  // Low-power overflow waits for the frame strobe
  assign timer_a_ovf = pend & (irq_strobe | ~align);
endmodule : lpmc_far_model

// File: lpmc_pkg.sv
// Constants and types for the low-power mode controller
package lpmc_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_CMD = 6'h04;
  localparam logic [5:0] OFS_IRQ = 6'h08;
  localparam logic [5:0] OFS_MISC = 6'h0c;
  localparam logic [5:0] OFS_STATUS = 6'h10;
  localparam logic [5:0] OFS_DTX = 6'h20;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_LOW_SPEED_ON_FLAG_BIT = 0;
  localparam int CTRL_TBS_BIT = 1;
  localparam int CTRL_IE_BIT = 2;
  localparam int CMD_STOP_BIT = 0;
  localparam int CMD_SBY_BIT = 1;
  localparam int IRQ_TA_FLAG_BIT = 0;
  localparam int IRQ_EZ_FLAG_BIT = 1;
  localparam int IRQ_TA_MASK_BIT = 2;
  localparam int IRQ_EZ_MASK_BIT = 3;
  localparam int MISC_FSEL_LSB = 0;
  localparam int MISC_PMOS_BIT = 2;
  localparam int MISC_OSC_BIT = 3;
  localparam int DTX_BIT = 3;
  localparam int STATUS_NOP_BIT = 3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [1:0] MASK_RST = 2'h3;
  localparam logic [3:0] MISC_RST = 4'h0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SYS_CLK_MHZ = 100;
  localparam int OSC_SETTLE_US = 100;
  localparam int SETTLE_CYC = OSC_SETTLE_US * SYS_CLK_MHZ;
  // Frame lengths in subclock ticks
  localparam int FRAME_TICKS_0 = 8;
  localparam int FRAME_TICKS_1 = 16;
  localparam int FRAME_TICKS_2 = 32;

  // ----------------------------------------
  // Operating modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    LPMC_ACTIVE = 3'b000,
    LPMC_STANDBY = 3'b001,
    LPMC_STOP = 3'b010,
    LPMC_WATCH = 3'b011,
    LPMC_SUBACTIVE = 3'b100,
    LPMC_DIRECT_WAIT = 3'b101,
    LPMC_SETTLE = 3'b110
  } lpmc_mode_t;

endpackage : lpmc_pkg

// File: lpmc_top.sv
// Low-power mode controller with interrupt frame and direct transfer
// ----------------------------------------
// Behaviour
// - Subactive CPU runs from the subclock
// - Subactive stop/standby goes to watch or active
// - Direct-transfer flag set only in subactive; auto-clears
// - Direct-transfer flag held at reset in active
// - Low-power interrupts follow the interrupt frame
// - Frame length chosen among three by register
// - Strobe to wake request takes settle time
// - Requests follow strobe, except during active transition
// - External edge counted at second strobe after
// - Timer A overflow aligned to strobe
// - Direct transfer enters active after settle time
// - Direct time between settle and frame plus settle
// - Reset returns device to active from anywhere
// - Stop/standby becomes no-op if interrupt blocked
// - Stop at strobe in subactive drops requests
// - Short high or low levels go undetected
// - Edge found by high-to-low consecutive samples
// - Watch wake goes active or subactive by flag
// - Watch entered by timebase stop or subactive stop
// ----------------------------------------
//
// The implementer's own choice: the Avalon-MM register port.
module lpmc_top #(
  parameter int SETTLE_CYCLES = lpmc_pkg::SETTLE_CYC,
  parameter int FRAME0 = lpmc_pkg::FRAME_TICKS_0,
  parameter int FRAME1 = lpmc_pkg::FRAME_TICKS_1,
  parameter int FRAME2 = lpmc_pkg::FRAME_TICKS_2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [lpmc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic subclk_tick,
  input wire logic timer_a_ovf,
  input wire logic ext_zero_n,
  output lpmc_pkg::lpmc_mode_t mode,
  output logic cpu_run,
  output logic cpu_clk_sub,
  output logic main_osc_en,
  output logic osc_fast_sel,
  output logic so_pmos_off,
  output logic irq_strobe,
  output logic cpu_irq
);
  import lpmc_pkg::*;

  generate
    if (SETTLE_CYCLES < 1 || FRAME0 < 2 || FRAME1 < FRAME0 ||
        FRAME2 < FRAME1) begin : g_bad_param
      $error("lpmc_top: bad settle or frame parameters");
    end
  endgenerate

  localparam int FW = $clog2(FRAME2 + 1);
  localparam int SW = $clog2(SETTLE_CYCLES + 1);

  lpmc_mode_t next_mode;
  logic ack;
  logic wr_ok;
  logic low_speed_on_flag;
  logic timebase_select_bit;
  logic global_irq_enable_flag;
  logic direct_transfer_flag;
  logic [3:0] misc_control_register;
  logic timer_a_request_flag;
  logic ext_zero_request_flag;
  logic ta_mask;
  logic ez_mask;
  logic nop_flag;
  logic ta_pend;
  logic ez_pend;
  logic ez_fall;
  logic [FW-1:0] frame_cnt;
  logic [FW-1:0] frame_last;
  logic [SW-1:0] settle_cnt;
  logic strobe;
  logic deliver;
  logic flag_gate;
  logic lose;
  logic ta_event;
  logic ez_event;
  logic irq_any;
  logic cmd_ok;
  logic cmd_stop;
  logic cmd_sby;
  logic cancel;
  logic eff_stop;
  logic eff_sby;

  // ----------------------------------------
  // Avalon-MM slave, one wait state
  // ----------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_ok = avs_write & ack;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read & ~ack) begin
      unique case (avs_address)
        OFS_CTRL: avs_readdata <= {29'h0, global_irq_enable_flag,
                                   timebase_select_bit, low_speed_on_flag};
        OFS_IRQ: avs_readdata <= {28'h0, ez_mask, ta_mask,
                                  ext_zero_request_flag,
                                  timer_a_request_flag};
        OFS_MISC: avs_readdata <= {28'h0, misc_control_register};
        OFS_STATUS: avs_readdata <= {28'h0, nop_flag, mode};
        OFS_DTX: avs_readdata <= {28'h0, direct_transfer_flag, 3'h0};
        default: avs_readdata <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {global_irq_enable_flag, timebase_select_bit,
       low_speed_on_flag} <= CTRL_RST;
    end else if (wr_ok && avs_address == OFS_CTRL) begin
      low_speed_on_flag <= avs_writedata[CTRL_LOW_SPEED_ON_FLAG_BIT];
      timebase_select_bit <= avs_writedata[CTRL_TBS_BIT];
      global_irq_enable_flag <= avs_writedata[CTRL_IE_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      misc_control_register <= MISC_RST;
    end else if (wr_ok && avs_address == OFS_MISC) begin
      misc_control_register <= avs_writedata[3:0];
    end
  end

  // Wrong setting upsets subclock logic; software owns it
  assign osc_fast_sel = misc_control_register[MISC_OSC_BIT];
  assign so_pmos_off = misc_control_register[MISC_PMOS_BIT];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {ez_mask, ta_mask} <= MASK_RST;
    end else if (wr_ok && avs_address == OFS_IRQ) begin
      ta_mask <= avs_writedata[IRQ_TA_MASK_BIT];
      ez_mask <= avs_writedata[IRQ_EZ_MASK_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      direct_transfer_flag <= 1'b0;
    end else if (mode == LPMC_ACTIVE) begin
      direct_transfer_flag <= 1'b0;
    end else if (wr_ok && avs_address == OFS_DTX &&
                 mode == LPMC_SUBACTIVE) begin
      direct_transfer_flag <= avs_writedata[DTX_BIT];
    end
  end

  // ----------------------------------------
  // Interrupt frame
  // ----------------------------------------
  always_comb begin
    unique case (misc_control_register[MISC_FSEL_LSB +: 2])
      2'h0: frame_last = FW'(FRAME0 - 1);
      2'h1: frame_last = FW'(FRAME1 - 1);
      default: frame_last = FW'(FRAME2 - 1);
    endcase
  end

  assign strobe = subclk_tick & (frame_cnt >= frame_last);
  assign irq_strobe = strobe;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame_cnt <= '0;
    end else if (strobe) begin
      frame_cnt <= '0;
    end else if (subclk_tick) begin
      frame_cnt <= frame_cnt + 1'b1;
    end
  end

  // ----------------------------------------
  // Event alignment
  // ----------------------------------------
  // Full-speed modes pass events at once; watch and subactive only
  // at a strobe; transitions to active hold them pending
  assign deliver = strobe &
                   (mode == LPMC_WATCH || mode == LPMC_SUBACTIVE);
  assign flag_gate = mode == LPMC_ACTIVE || mode == LPMC_STANDBY ||
                     deliver;
  assign lose = deliver & cmd_ok & (cmd_stop | cmd_sby) &
                mode == LPMC_SUBACTIVE;

  lpmc_ext0_edge u_ext0_edge (
    .sys_clk(sys_clk),
    .rst(rst),
    .sample_en((mode == LPMC_ACTIVE || mode == LPMC_STANDBY) |
               (strobe && mode != LPMC_STOP)),
    .pin_n(ext_zero_n),
    .fall(ez_fall)
  );

  assign ta_event = (ta_pend | timer_a_ovf) & flag_gate & ~lose;
  assign ez_event = (ez_pend | ez_fall) & flag_gate & ~lose;

  always_ff @(posedge sys_clk) begin
    if (rst || mode == LPMC_STOP || flag_gate) begin
      ta_pend <= 1'b0;
    end else if (timer_a_ovf) begin
      ta_pend <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || mode == LPMC_STOP || flag_gate) begin
      ez_pend <= 1'b0;
    end else if (ez_fall) begin
      ez_pend <= 1'b1;
    end
  end

  // A set in the clearing cycle wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timer_a_request_flag <= 1'b0;
    end else if (ta_event) begin
      timer_a_request_flag <= 1'b1;
    end else if (wr_ok && avs_address == OFS_IRQ &&
                 avs_writedata[IRQ_TA_FLAG_BIT]) begin
      timer_a_request_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ext_zero_request_flag <= 1'b0;
    end else if (ez_event) begin
      ext_zero_request_flag <= 1'b1;
    end else if (wr_ok && avs_address == OFS_IRQ &&
                 avs_writedata[IRQ_EZ_FLAG_BIT]) begin
      ext_zero_request_flag <= 1'b0;
    end
  end

  assign irq_any = (timer_a_request_flag & ~ta_mask) |
                   (ext_zero_request_flag & ~ez_mask);
  assign cpu_irq = irq_any & global_irq_enable_flag &
                   (mode == LPMC_ACTIVE || mode == LPMC_SUBACTIVE);

  // ----------------------------------------
  // Stop and standby commands
  // ----------------------------------------
  assign cmd_ok = wr_ok && avs_address == OFS_CMD &&
                  (mode == LPMC_ACTIVE || mode == LPMC_SUBACTIVE);
  assign cmd_stop = avs_writedata[CMD_STOP_BIT];
  assign cmd_sby = avs_writedata[CMD_SBY_BIT] & ~cmd_stop;
  // Pending unmasked flag with interrupts off would never wake us
  assign cancel = ~global_irq_enable_flag & irq_any;
  assign eff_stop = cmd_ok & cmd_stop & ~cancel;
  assign eff_sby = cmd_ok & cmd_sby & ~cancel;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nop_flag <= 1'b0;
    end else if (cmd_ok & (cmd_stop | cmd_sby)) begin
      nop_flag <= cancel;
    end
  end

  // ----------------------------------------
  // Mode sequencer
  // ----------------------------------------
  always_comb begin
    next_mode = mode;
    unique case (mode)
      LPMC_ACTIVE: begin
        if (eff_stop) begin
          next_mode = timebase_select_bit ? LPMC_WATCH : LPMC_STOP;
        end else if (eff_sby) begin
          next_mode = LPMC_STANDBY;
        end
      end
      LPMC_STANDBY: begin
        if (irq_any) begin
          next_mode = LPMC_ACTIVE;
        end
      end
      LPMC_STOP: begin
        next_mode = LPMC_STOP;
      end
      LPMC_WATCH: begin
        if (ta_event | ez_event) begin
          next_mode = low_speed_on_flag ? LPMC_SUBACTIVE
                                        : LPMC_SETTLE;
        end
      end
      LPMC_SUBACTIVE: begin
        if (eff_stop | eff_sby) begin
          if (~low_speed_on_flag & direct_transfer_flag) begin
            next_mode = LPMC_DIRECT_WAIT;
          end else begin
            next_mode = LPMC_WATCH;
          end
        end
      end
      LPMC_DIRECT_WAIT: begin
        // Frame alignment keeps the transfer under frame plus settle
        if (strobe) begin
          next_mode = LPMC_SETTLE;
        end
      end
      LPMC_SETTLE: begin
        if (settle_cnt == SW'(SETTLE_CYCLES - 1)) begin
          next_mode = LPMC_ACTIVE;
        end
      end
      default: next_mode = LPMC_ACTIVE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode <= LPMC_ACTIVE;
    end else begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || mode != LPMC_SETTLE) begin
      settle_cnt <= '0;
    end else begin
      settle_cnt <= settle_cnt + 1'b1;
    end
  end

  // ----------------------------------------
  // Clock and oscillator controls
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cpu_run <= 1'b1;
      cpu_clk_sub <= 1'b0;
      main_osc_en <= 1'b1;
    end else begin
      cpu_run <= next_mode == LPMC_ACTIVE ||
                 next_mode == LPMC_SUBACTIVE;
      cpu_clk_sub <= next_mode == LPMC_SUBACTIVE;
      main_osc_en <= next_mode == LPMC_ACTIVE ||
                     next_mode == LPMC_STANDBY ||
                     next_mode == LPMC_SETTLE;
    end
  end

endmodule : lpmc_top

// File: lpmc_top_asserts.sv
// Port-level assertion checker for the low-power mode controller
module lpmc_top_asserts #(
  parameter int SETTLE_CYCLES = lpmc_pkg::SETTLE_CYC,
  parameter int FRAME0 = lpmc_pkg::FRAME_TICKS_0,
  parameter int FRAME1 = lpmc_pkg::FRAME_TICKS_1,
  parameter int FRAME2 = lpmc_pkg::FRAME_TICKS_2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [lpmc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic subclk_tick,
  input wire lpmc_pkg::lpmc_mode_t mode,
  input wire logic cpu_run,
  input wire logic cpu_clk_sub,
  input wire logic main_osc_en,
  input wire logic osc_fast_sel,
  input wire logic so_pmos_off,
  input wire logic irq_strobe,
  input wire logic cpu_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  import lpmc_pkg::*;
  int settle_cnt;
  always_ff @(posedge sys_clk) begin
    if (rst || mode != LPMC_SETTLE) begin
      settle_cnt <= 0;
    end else begin
      settle_cnt <= settle_cnt + 1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_bus_wait: assert property (
    $rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus wait state count wrong");
  a_sub_clock: assert property (
    cpu_clk_sub == (mode == LPMC_SUBACTIVE))
    else $error("subclock select wrong");
  a_watch_osc: assert property (
    mode == LPMC_WATCH |-> !main_osc_en && !cpu_run)
    else $error("watch clocks wrong");
  a_watch_exit: assert property (
    mode == LPMC_WATCH |=>
      mode inside {LPMC_WATCH, LPMC_SUBACTIVE, LPMC_SETTLE})
    else $error("bad exit from watch");
  a_direct_step: assert property (
    mode == LPMC_DIRECT_WAIT |=>
      mode == ($past(irq_strobe) ? LPMC_SETTLE : LPMC_DIRECT_WAIT))
    else $error("direct wait not ended by strobe");
  a_settle_len: assert property (
    $fell(mode == LPMC_SETTLE) |->
      mode == LPMC_ACTIVE && settle_cnt == SETTLE_CYCLES)
    else $error("settle length wrong");
  a_watch_frame: assert property (
    mode == LPMC_WATCH && !irq_strobe |=> mode == LPMC_WATCH)
    else $error("watch left off the strobe");
  a_irq_mode: assert property (
    cpu_irq |-> mode inside {LPMC_ACTIVE, LPMC_SUBACTIVE})
    else $error("request while cpu halted");
  a_stop_hold: assert property (
    mode == LPMC_STOP |=> mode == LPMC_STOP)
    else $error("stop left without reset");
  a_misc_pins: assert property (
    avs_write && !avs_waitrequest && avs_address == OFS_MISC |=>
      {osc_fast_sel, so_pmos_off} == $past(avs_writedata[3:2]))
    else $error("misc pins not updated");
  a_dtx_active: assert property (
    avs_read && !avs_waitrequest && avs_address == OFS_DTX &&
      mode == LPMC_ACTIVE && $past(mode) == LPMC_ACTIVE &&
      $past(mode, 2) == LPMC_ACTIVE |-> !avs_readdata[3])
    else $error("direct flag set in active");
endmodule : lpmc_top_asserts

bind lpmc_top lpmc_top_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES),
  .FRAME0(FRAME0), .FRAME1(FRAME1), .FRAME2(FRAME2)) u_lpmc_top_asserts (
  .sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_readdata, .avs_waitrequest, .subclk_tick, .mode, .cpu_run,
  .cpu_clk_sub, .main_osc_en, .osc_fast_sel, .so_pmos_off, .irq_strobe,
  .cpu_irq);

// File: lpmc_top_bench.sv
// Self-checking bench for the low-power mode controller
module lpmc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import lpmc_pkg::*;
  localparam int SET = 20;
  localparam int DIV = 4;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, subclk_tick, timer_a_ovf, ext_zero_n;
  logic cpu_run, cpu_clk_sub, main_osc_en, osc_fast_sel, so_pmos_off;
  logic irq_strobe, cpu_irq, ovf_go = 1'b0, align = 1'b0, ext_lvl = 1'b1;
  logic [3:0] v;
  lpmc_mode_t mode;
  int fail_count = 0, check_count = 0, cyc = 0, n, t;
  logic [5:0] ra [6] = '{OFS_CTRL, OFS_IRQ, OFS_MISC, OFS_STATUS, OFS_DTX,
    6'h3c};
  logic [31:0] rv [6] = '{32'h0, 32'hc, 32'h0, 32'h0, 32'h0, 32'h0};
  // 100 MHz main clock, well clear of the band the subclock logic dislikes
  always #5 sys_clk = ~sys_clk;
  lpmc_top #(.SETTLE_CYCLES(SET)) u_lpmc_top (.sys_clk, .rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .subclk_tick, .timer_a_ovf, .ext_zero_n, .mode, .cpu_run, .cpu_clk_sub,
    .main_osc_en, .osc_fast_sel, .so_pmos_off, .irq_strobe, .cpu_irq);
  lpmc_far_model #(.SUB_DIV(DIV)) u_lpmc_far_model (.sys_clk, .ovf_go,
    .align, .ext_lvl, .irq_strobe, .subclk_tick, .timer_a_ovf, .ext_zero_n);
  // ----
  // Checking and bus tasks
  // ----
  task tally_and_finish();
    if (fail_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk32
  task chk_mode(input lpmc_mode_t got, input lpmc_mode_t exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: mode %h expected %h", $time, got, exp);
    end
  endtask : chk_mode
  // Request held until waitrequest is seen low at a rising edge
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    chk32(32'(k < 20), 32'h1);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task rd(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk32(q, e);
  endtask : rd
  task wait_mode(input lpmc_mode_t m, input int lim);
    n = 0;
    @(negedge sys_clk);
    while (mode !== m && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
    chk_mode(mode, m);
    @(posedge sys_clk);
  endtask : wait_mode
  task fire_ovf();
    ovf_go <= 1'b1;
    @(posedge sys_clk);
    ovf_go <= 1'b0;
    @(posedge sys_clk);
  endtask : fire_ovf
  // Ticks from one strobe to the next, after syncing to a strobe
  task frame_ticks();
    int k;
    k = 0;
    @(negedge sys_clk);
    while (irq_strobe !== 1'b1 && k < 1500) begin
      @(negedge sys_clk);
      k++;
    end
    t = 0;
    do begin
      @(negedge sys_clk);
      t += int'(subclk_tick);
      k++;
    end while (irq_strobe !== 1'b1 && k < 1500);
    @(posedge sys_clk);
  endtask : frame_ticks
  function automatic int exp_frame(input int s);
    return s == 0 ? FRAME_TICKS_0 : s == 1 ? FRAME_TICKS_1 : FRAME_TICKS_2;
  endfunction : exp_frame
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      $display("Error at %0t: timeout", $time);
      tally_and_finish();
    end
  end
  // ----
  // Main sequence
  // ----
  initial begin
    void'($urandom(32'hd59a));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    foreach (ra[i]) rd(ra[i], rv[i]);
    repeat (4) begin
      v = 4'($urandom);
      wr(OFS_MISC, {28'hfffffff, v});
      rd(OFS_MISC, {28'h0, v});
      chk32({30'h0, osc_fast_sel, so_pmos_off}, {30'h0, v[3:2]});
    end
    wr(OFS_MISC, 32'h0);
    wr(OFS_DTX, 32'h8);
    rd(OFS_DTX, 32'h0);
    wr(OFS_IRQ, 32'h8);
    wr(OFS_CMD, 32'h2);
    wait_mode(LPMC_STANDBY, 2);
    fire_ovf();
    wait_mode(LPMC_ACTIVE, 50);
    rd(OFS_IRQ, 32'h9);
    fire_ovf();
    wr(OFS_CMD, 32'h1);
    wait_mode(LPMC_ACTIVE, 2);
    rd(OFS_STATUS, 32'h8);
    wr(OFS_IRQ, 32'h9);
    align <= 1'b1;
    wr(OFS_CTRL, 32'h3);
    wr(OFS_CMD, 32'h1);
    wait_mode(LPMC_WATCH, 2);
    fire_ovf();
    wait_mode(LPMC_SUBACTIVE, 400);
    chk32({29'h0, cpu_run, cpu_clk_sub, main_osc_en}, 32'h6);
    wr(OFS_IRQ, 32'h9);
    for (int s = 0; s < 4; s++) begin
      wr(OFS_MISC, 32'(s));
      frame_ticks();
      chk32(32'(t), 32'(exp_frame(s)));
    end
    wr(OFS_MISC, 32'h0);
    wr(OFS_CMD, 32'h2);
    wait_mode(LPMC_WATCH, 2);
    chk32({29'h0, cpu_run, cpu_clk_sub, main_osc_en}, 32'h0);
    fire_ovf();
    wait_mode(LPMC_SUBACTIVE, 400);
    wr(OFS_IRQ, 32'h9);
    wr(OFS_CTRL, 32'h2);
    wr(OFS_DTX, 32'h8);
    rd(OFS_DTX, 32'h8);
    wr(OFS_CMD, 32'h1);
    wait_mode(LPMC_ACTIVE, 400);
    chk32(32'(n + 1 > SET && n + 1 <= FRAME_TICKS_0 * DIV + SET), 32'h1);
    rd(OFS_DTX, 32'h0);
    wr(OFS_IRQ, 32'h4);
    wr(OFS_CMD, 32'h1);
    wait_mode(LPMC_WATCH, 2);
    frame_ticks();
    ext_lvl <= 1'b0;
    repeat (5) @(posedge sys_clk);
    ext_lvl <= 1'b1;
    repeat (150) @(posedge sys_clk);
    wait_mode(LPMC_WATCH, 2);
    ext_lvl <= 1'b0;
    wait_mode(LPMC_ACTIVE, 400);
    ext_lvl <= 1'b1;
    rd(OFS_IRQ, 32'h6);
    wr(OFS_CTRL, 32'h4);
    chk32({31'h0, cpu_irq}, 32'h1);
    align <= 1'b0;
    wr(OFS_IRQ, 32'h6);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CMD, 32'h1);
    wait_mode(LPMC_STOP, 2);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    wait_mode(LPMC_ACTIVE, 2);
    rd(OFS_IRQ, 32'hc);
    tally_and_finish();
  end
endmodule : lpmc_top_bench
